// ===== mcr_modem_config_regs.sv
// modem configuration register bank with Avalon-MM slave
//
// Contract
// - chan filter exponent bits 7:6 and mantissa bits 5:4 set decimation
// - symbol-rate exponent is 4-bit rw field at bits 3:0, reset 1100
// - symbol rate mantissa has nine bits, ninth an implicit one
// - rate equals (256+mantissa) times 2^exp over 2^28 times reference
// - symbol-rate mantissa is a full rw byte resetting to 0x22
// - bit 7 of third register bypasses dc block filter, reset 0
// - modulation field bits 6:4 resets 000; 000 2-FSK, 001 GFSK
module mcr_modem_config_regs (
	input wire logic clk, // 40 MHz system clock
	input wire logic rst, // synchronous active-high reset
	input wire logic [15:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data, low byte used
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall until ack cycle
	output mcr_pkg::mcr_cfg_t cfg, // fields to filter, rate gen, demod
	output logic [8:0] symrate_full_mant, // mantissa with hidden one
	output logic modulation_defined // code is 2-FSK, GFSK or MSK
);
	import mcr_pkg::*;

	mcr_bus_st_t st_q, st_d;
	mcr_cfg_t cfg_q, cfg_d;
	logic [31:0] rdata_q, rdata_d;
	logic req;
	logic [7:0] wbyte;
	logic wen;

	assign req = avs_read | avs_write;
	assign wbyte = avs_writedata[7:0];
	// only lane 0 carries register data; other lanes are ignored
	assign wen = (st_q == MCR_ACK) && avs_write && avs_byteenable[0];

	// one wait cycle then ack; gives a registered readdata path
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			MCR_IDLE: begin
				if (req) begin
					st_d = MCR_ACK;
				end
			end
			MCR_ACK: begin
				st_d = MCR_IDLE;
			end
			// a corrupted code falls back to idle rather than locking the bus
			default: begin
				st_d = MCR_IDLE;
			end
		endcase
	end
	// stall only while a request waits for its ack cycle
	assign avs_waitrequest = req && (st_q != MCR_ACK);

	// the bus state is always one of the two one-hot codes
	bus_state_onehot_a: assert property (@(posedge clk) disable iff (rst)
		$onehot(st_q))
		else $error("bus state not one-hot");
	// the ack comes one cycle after the request is taken
	ack_one_wait_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == MCR_IDLE && req) |=> !avs_waitrequest)
		else $error("ack not one cycle after request");

	// register updates at the acking edge
	always_comb begin
		cfg_d = cfg_q;
		if (wen) begin
			unique case (avs_address)
				MCR_OFS_BW_EXP: begin
					cfg_d.chan_filter_exp = wbyte[MCR_CHAN_EXP_LSB +: 2];
					cfg_d.chan_filter_mant = wbyte[MCR_CHAN_MANT_LSB +: 2];
					cfg_d.symrate_exp = wbyte[MCR_SYM_EXP_LSB +: 4];
				end
				MCR_OFS_MANT: begin
					cfg_d.symrate_mant = wbyte;
				end
				MCR_OFS_FMT: begin
					cfg_d.dc_block_bypass = wbyte[MCR_DC_BYPASS_BIT];
					cfg_d.modulation_select = wbyte[MCR_MOD_LSB +: 3];
				end
				default: begin
					cfg_d = cfg_q; // unmapped write is dropped
				end
			endcase
		end
	end

	// each accepted write lands in its fields at the acking edge
	exp_write_a: assert property (@(posedge clk) disable iff (rst)
		(wen && avs_address == MCR_OFS_BW_EXP)
		|=> cfg.symrate_exp == $past(avs_writedata[3:0])
		&& cfg.chan_filter_exp == $past(avs_writedata[7:6]))
		else $error("exponent write lost");
	chan_mant_a: assert property (@(posedge clk) disable iff (rst)
		(wen && avs_address == MCR_OFS_BW_EXP)
		|=> cfg.chan_filter_mant == $past(avs_writedata[5:4]))
		else $error("channel mantissa write lost");
	mant_write_a: assert property (@(posedge clk) disable iff (rst)
		(wen && avs_address == MCR_OFS_MANT)
		|=> cfg.symrate_mant == $past(avs_writedata[7:0]))
		else $error("mantissa write lost");
	fmt_write_a: assert property (@(posedge clk) disable iff (rst)
		(wen && avs_address == MCR_OFS_FMT)
		|=> cfg.dc_block_bypass == $past(avs_writedata[7])
		&& cfg.modulation_select == $past(avs_writedata[6:4]))
		else $error("format write lost");
	// writes outside the three offsets or with lane 0 off leave every field alone
	unmapped_write_a: assert property (@(posedge clk) disable iff (rst)
		(wen && avs_address != MCR_OFS_BW_EXP && avs_address != MCR_OFS_MANT
		&& avs_address != MCR_OFS_FMT)
		|=> $stable(cfg))
		else $error("unmapped write changed a field");
	lane_off_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == MCR_ACK && avs_write && !avs_byteenable[0]) |=> $stable(cfg))
		else $error("write with lane 0 off changed a field");

	// readback; low nibble of the format register reads zero here
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (st_q == MCR_IDLE && avs_read) begin
			unique case (avs_address)
				MCR_OFS_BW_EXP: rdata_d[7:0] = {cfg_q.chan_filter_exp, cfg_q.chan_filter_mant, cfg_q.symrate_exp};
				MCR_OFS_MANT: rdata_d[7:0] = cfg_q.symrate_mant;
				MCR_OFS_FMT: rdata_d[7:0] = {cfg_q.dc_block_bypass, cfg_q.modulation_select, 4'h0};
				default: rdata_d = 32'h0000_0000; // unmapped reads zero
			endcase
		end else if (st_q == MCR_ACK) begin
			rdata_d = rdata_q;
		end
	end

	// read data stands at the ack edge with the register image in the low byte
	read_back_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == MCR_IDLE && avs_read && avs_address == MCR_OFS_MANT)
		|=> avs_readdata == {24'h00_0000, cfg.symrate_mant})
		else $error("mantissa readback wrong");
	bw_read_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == MCR_IDLE && avs_read && avs_address == MCR_OFS_BW_EXP)
		|=> avs_readdata == {24'h00_0000, cfg.chan_filter_exp, cfg.chan_filter_mant, cfg.symrate_exp})
		else $error("filter and exponent readback wrong");
	fmt_read_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == MCR_IDLE && avs_read && avs_address == MCR_OFS_FMT)
		|=> avs_readdata == {24'h00_0000, cfg.dc_block_bypass, cfg.modulation_select, 4'h0})
		else $error("format readback wrong");
	// unmapped reads answer zero rather than stale data
	hole_read_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == MCR_IDLE && avs_read && avs_address != MCR_OFS_BW_EXP
		&& avs_address != MCR_OFS_MANT && avs_address != MCR_OFS_FMT)
		|=> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// bus handshake state
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= MCR_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// configuration fields; reset puts filter, rate and format at their defaults
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_q <= '{chan_filter_exp: MCR_RST_CHAN_EXP, chan_filter_mant: MCR_RST_CHAN_MANT,
				symrate_exp: MCR_RST_SYM_EXP, symrate_mant: MCR_RST_SYM_MANT,
				dc_block_bypass: MCR_RST_DC_BYPASS, modulation_select: MCR_RST_MOD};
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// read data register, held through the ack and cleared by the next idle cycle with no read
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// fields move only on an accepted write
	stable_cfg_a: assert property (@(posedge clk) disable iff (rst)
		!wen |=> $stable(cfg))
		else $error("config changed without write");
	// every field holds its reset value at the first edge after a reset cycle
	reset_val_a: assert property (@(posedge clk)
		(!rst && $past(rst))
		|-> cfg.chan_filter_exp == MCR_RST_CHAN_EXP && cfg.chan_filter_mant == MCR_RST_CHAN_MANT
		&& cfg.symrate_exp == MCR_RST_SYM_EXP && cfg.symrate_mant == MCR_RST_SYM_MANT
		&& cfg.dc_block_bypass == MCR_RST_DC_BYPASS && cfg.modulation_select == MCR_RST_MOD)
		else $error("reset value wrong");

	assign avs_readdata = rdata_q;
	// outputs are the stored fields, no extra stage
	assign cfg = cfg_q;
	// the rate generator needs the implicit one to form (256+m)<<e >> 28
	assign symrate_full_mant = MCR_SYM_HIDDEN_ONE | {1'b0, cfg_q.symrate_mant};

	// the ninth mantissa bit is always one and never stored
	hidden_one_a: assert property (@(posedge clk) disable iff (rst)
		symrate_full_mant[8] && symrate_full_mant[7:0] == cfg.symrate_mant)
		else $error("hidden one missing");

	// reserved codes are stored but flagged so the demod holds its default path
	assign modulation_defined = (cfg_q.modulation_select == MCR_MOD_2FSK) ||
		(cfg_q.modulation_select == MCR_MOD_GFSK) || (cfg_q.modulation_select == MCR_MOD_MSK);

	// 2-FSK and GFSK are always usable formats
	known_mod_a: assert property (@(posedge clk) disable iff (rst)
		(cfg.modulation_select == MCR_MOD_2FSK || cfg.modulation_select == MCR_MOD_GFSK)
		|-> modulation_defined)
		else $error("defined format flagged reserved");
	// code 010 is reserved and must not pass as a format
	rsvd_flag_a: assert property (@(posedge clk) disable iff (rst)
		(cfg.modulation_select == 3'h2) |-> !modulation_defined)
		else $error("reserved format flagged defined");

	// main scenarios: writes, reads, reserved and MSK formats, dc filter bypass
	cov_wr_c: cover property (@(posedge clk) disable iff (rst) wen);
	cov_rd_c: cover property (@(posedge clk) disable iff (rst) st_q == MCR_ACK && avs_read);
	cov_rsvd_c: cover property (@(posedge clk) disable iff (rst) !modulation_defined);
	cov_msk_c: cover property (@(posedge clk) disable iff (rst) cfg.modulation_select == MCR_MOD_MSK);
	cov_bypass_c: cover property (@(posedge clk) disable iff (rst) cfg.dc_block_bypass);
endmodule : mcr_modem_config_regs

// ===== mcr_pkg.sv
// package for the modem configuration register bank
package mcr_pkg;
	// byte offsets of the three registers
	localparam logic [15:0] MCR_OFS_BW_EXP = 16'hDF0C;
	localparam logic [15:0] MCR_OFS_MANT = 16'hDF0D;
	localparam logic [15:0] MCR_OFS_FMT = 16'hDF0E;
	// reset values
	localparam logic [1:0] MCR_RST_CHAN_EXP = 2'h2;
	localparam logic [1:0] MCR_RST_CHAN_MANT = 2'h0;
	localparam logic [3:0] MCR_RST_SYM_EXP = 4'hC;
	localparam logic [7:0] MCR_RST_SYM_MANT = 8'h22;
	localparam logic MCR_RST_DC_BYPASS = 1'b0;
	localparam logic [2:0] MCR_RST_MOD = 3'h0;
	// field positions
	localparam int MCR_CHAN_EXP_LSB = 6;
	localparam int MCR_CHAN_MANT_LSB = 4;
	localparam int MCR_SYM_EXP_LSB = 0;
	localparam int MCR_DC_BYPASS_BIT = 7;
	localparam int MCR_MOD_LSB = 4;
	// modulation codes
	localparam logic [2:0] MCR_MOD_2FSK = 3'h0;
	localparam logic [2:0] MCR_MOD_GFSK = 3'h1;
	localparam logic [2:0] MCR_MOD_MSK = 3'h7;
	// symbol-rate format: implicit leading one in the mantissa
	localparam logic [8:0] MCR_SYM_HIDDEN_ONE = 9'h100;
	localparam int MCR_SYM_RATE_SHIFT = 28;

	// bus state
	typedef enum logic [1:0] {
		MCR_IDLE = 2'b01,
		MCR_ACK = 2'b10
	} mcr_bus_st_t;

	// configuration exported to the datapath
	typedef struct packed {
		logic [1:0] chan_filter_exp;
		logic [1:0] chan_filter_mant;
		logic [3:0] symrate_exp;
		logic [7:0] symrate_mant;
		logic dc_block_bypass;
		logic [2:0] modulation_select;
	} mcr_cfg_t;
endpackage : mcr_pkg

// ===== tb_mcr.sv
// self-checking bench for the modem configuration register bank
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import mcr_pkg::*;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, modulation_defined;
	logic [15:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [3:0] avs_byteenable;
	logic [8:0] symrate_full_mant;
	logic [2:0] code;
	mcr_cfg_t cfg;
	int err_total = 0;
	int num_checks = 0;
	mcr_modem_config_regs u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfg(cfg),
		.symrate_full_mant(symrate_full_mant), .modulation_defined(modulation_defined));
	// 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	// one bus transfer, held until waitrequest is sampled low; read data kept in d
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] wd, input logic [3:0] be);
		@(posedge clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= {24'h000000, wd};
		avs_byteenable <= be;
		// no cycle limit of our own: the watchdog ends a wait that never finishes
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	// watchdog: the tests need under two hundred cycles
	initial begin
		#200000;
		err_total++;
		results();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 16'h0000;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(cfg, {2'h2, 2'h0, 4'hC, 8'h22, 1'b0, 3'h0});
		chk(symrate_full_mant, 32'h122);
		xfer(1'b0, MCR_OFS_BW_EXP, 8'h00, 4'h1);
		chk(d, 32'h8C);
		xfer(1'b0, MCR_OFS_MANT, 8'h00, 4'h1);
		chk(d, 32'h22);
		xfer(1'b0, MCR_OFS_FMT, 8'h00, 4'h1);
		chk(d, 32'h00);
		$display("test reset values done");
		// boundary values of the first two registers, checked at the ack edge
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, MCR_OFS_BW_EXP, i ? 8'h00 : 8'hFF, 4'h1);
			#1 chk({cfg.chan_filter_exp, cfg.chan_filter_mant, cfg.symrate_exp}, i ? 8'h00 : 8'hFF);
			xfer(1'b1, MCR_OFS_MANT, i ? 8'h00 : 8'hFF, 4'h1);
			#1 chk(symrate_full_mant, i ? 32'h100 : 32'h1FF);
			xfer(1'b0, MCR_OFS_MANT, 8'h00, 4'h1);
			chk(d, i ? 32'h00 : 32'hFF);
		end
		$display("test rate fields done");
		// half the reset symbol rate: above 26 and at most 100 kBaud, so MSK and bypass below are legal
		xfer(1'b1, MCR_OFS_BW_EXP, 8'h8B, 4'h1);
		xfer(1'b1, MCR_OFS_MANT, MCR_RST_SYM_MANT, 4'h1);
		// every modulation code with both bypass settings; low nibble is not stored
		for (int i = 0; i < 16; i++) begin
			code = i[2:0];
			xfer(1'b1, MCR_OFS_FMT, {i[3], code, 4'hF}, 4'h1);
			#1 chk({cfg.dc_block_bypass, cfg.modulation_select}, {i[3], code});
			chk(modulation_defined, (code == 3'h0 || code == 3'h1 || code == 3'h7));
			xfer(1'b0, MCR_OFS_FMT, 8'h00, 4'h1);
			chk(d, {i[3], code, 4'h0});
		end
		$display("test format codes done");
		// refused writes: unmapped place and disabled byte lane leave state alone
		xfer(1'b1, 16'hDF0F, 8'hAB, 4'h1);
		xfer(1'b0, 16'hDF0F, 8'h00, 4'h1);
		chk(d, 32'h00);
		xfer(1'b1, MCR_OFS_MANT, 8'h5A, 4'h0);
		xfer(1'b0, MCR_OFS_MANT, 8'h00, 4'h1);
		chk(d, 32'h22);
		$display("test refused writes done");
		// mid-run reset brings every field back from the mid-rate setup
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk(cfg, {MCR_RST_CHAN_EXP, MCR_RST_CHAN_MANT, MCR_RST_SYM_EXP, MCR_RST_SYM_MANT,
			MCR_RST_DC_BYPASS, MCR_RST_MOD});
		xfer(1'b0, MCR_OFS_BW_EXP, 8'h00, 4'h1);
		chk(d, 32'h8C);
		$display("test mid-run reset done");
		results();
	end
endmodule : tb
